// File: verilog/wave_ctrl_pkg.sv
// Package of constants, types and encodings for the 16-bit timer waveform controller.
//
// Behaviour
// - Control A: modes 7:6, 5:4, force 3:2.
// - Nonzero output mode overrides port pin; here 01 in PWM modes leaves the pin, except A in modes 9 and 15.
// - Non-PWM: disconnect, toggle, clear, set on match.
// - Fast PWM: 10 clear/set-at-top, 11 inverse.
// - Fast PWM 01 toggles A only mode 15.
// - Fast PWM compare equal TOP ignored.
// - Phase PWM 01 toggles A mode 9 only.
// - Phase PWM 10 clear up, set down.
// - Force strobes act only in non-PWM modes.
// - Force applies immediate match per output mode.
// - Force sets no flag, clears no counter.
// - Force bits always read zero.
// - Mode is four bits; mode 13 reserved.
// - Modes 0,4,12 immediate update, flag at MAX.
// - Modes 1-3 fixed TOP, update TOP, flag BOTTOM.
// - Fast modes update TOP, flag at TOP.
// - Modes 8,9 update and flag at BOTTOM.
// - Modes 10,11 update TOP, flag BOTTOM.
// - Dual-slope counts up to TOP, down.
`default_nettype none
package wave_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL_A   = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B   = 3'h1;
	localparam logic [2:0] ADDR_CMP_A    = 3'h2;
	localparam logic [2:0] ADDR_CMP_B    = 3'h3;
	localparam logic [2:0] ADDR_CAPTURE  = 3'h4;
	localparam logic [2:0] ADDR_COUNT    = 3'h5;
	localparam logic [2:0] ADDR_STATUS   = 3'h6;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_A_OUT_A_LSB = 6;
	localparam int CTRL_A_OUT_B_LSB = 4;
	localparam int CTRL_A_FORCE_A   = 3;
	localparam int CTRL_A_FORCE_B   = 2;
	localparam int CTRL_B_WGM_LSB   = 3;
	localparam int CTRL_B_RUN       = 0;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;

	// ----------------------------------------------------------------
	// Counter limits
	// ----------------------------------------------------------------
	localparam logic [15:0] TOP_MAX    = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT   = 16'h00FF;
	localparam logic [15:0] TOP_9BIT   = 16'h01FF;
	localparam logic [15:0] TOP_10BIT  = 16'h03FF;
	localparam logic [15:0] BOTTOM     = 16'h0000;

	// ----------------------------------------------------------------
	// Waveform mode numbers
	// ----------------------------------------------------------------
	localparam logic [3:0] WGM_NORMAL   = 4'h0;
	localparam logic [3:0] WGM_PC8      = 4'h1;
	localparam logic [3:0] WGM_PC9      = 4'h2;
	localparam logic [3:0] WGM_PC10     = 4'h3;
	localparam logic [3:0] WGM_CTC_CMP  = 4'h4;
	localparam logic [3:0] WGM_FAST8    = 4'h5;
	localparam logic [3:0] WGM_FAST9    = 4'h6;
	localparam logic [3:0] WGM_FAST10   = 4'h7;
	localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
	localparam logic [3:0] WGM_PFC_CMP  = 4'h9;
	localparam logic [3:0] WGM_PC_CAP   = 4'hA;
	localparam logic [3:0] WGM_PC_CMP   = 4'hB;
	localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
	localparam logic [3:0] WGM_RESERVED = 4'hD;
	localparam logic [3:0] WGM_FAST_CAP = 4'hE;
	localparam logic [3:0] WGM_FAST_CMP = 4'hF;

	// Output mode field codes.
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	// Counting family decoded from the mode number.
	typedef enum logic [3:0] {
		FAM_SINGLE = 4'b0001,
		FAM_FAST   = 4'b0010,
		FAM_PHASE  = 4'b0100,
		FAM_PFC    = 4'b1000
	} family_t;

	// Register bus request carried as one bundle.
	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

endpackage : wave_ctrl_pkg
`default_nettype wire

// File: verilog/wave_ctrl.sv
// Waveform mode and compare output control for a 16-bit timer/counter.
`timescale 1ns/100ps
`default_nettype none
module wave_ctrl
	import wave_ctrl_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire bus_req_t    bus_req,
	output var  logic [15:0] rdata,
	output var  logic        wave_out_a,
	output var  logic        wave_out_b,
	output var  logic        override_a,
	output var  logic        override_b,
	output var  logic        overflow_flag,
	output var  logic        count_up
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_a_reg;
	logic [7:0]  ctrl_b_reg;
	logic [15:0] cmp_a_buf_reg;
	logic [15:0] cmp_b_buf_reg;
	logic [15:0] cmp_a_reg;
	logic [15:0] cmp_b_reg;
	logic [15:0] capture_reg;
	logic [15:0] count_reg;
	logic        up_reg;
	logic        wave_a_reg;
	logic        wave_b_reg;
	logic        flag_reg;
	logic [15:0] rdata_reg;

	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------

	// Maps a mode number to its counting family.
	function automatic family_t family_of(input logic [3:0] m);
		family_t f;
		f = FAM_SINGLE;
		case (m)
			WGM_FAST8, WGM_FAST9, WGM_FAST10, WGM_FAST_CAP, WGM_FAST_CMP: f = FAM_FAST;
			WGM_PC8, WGM_PC9, WGM_PC10, WGM_PC_CAP, WGM_PC_CMP:          f = FAM_PHASE;
			WGM_PFC_CAP, WGM_PFC_CMP:                                    f = FAM_PFC;
			default:                                                     f = FAM_SINGLE;
		endcase
		return f;
	endfunction : family_of

	// Applies one compare event to an output; om selects toggle, clear, set or no change.
	function automatic logic apply_out(input logic cur, input logic [1:0] om);
		logic v;
		v = cur;
		case (om)
			OM_TOGGLE: v = ~cur;
			OM_CLEAR:  v = 1'b0;
			OM_SET:    v = 1'b1;
			default:   v = cur;
		endcase
		return v;
	endfunction : apply_out

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire logic [1:0] om_a     = ctrl_a_reg[CTRL_A_OUT_A_LSB +: 2];
	wire logic [1:0] om_b     = ctrl_a_reg[CTRL_A_OUT_B_LSB +: 2];
	wire logic [3:0] wgm      = {ctrl_b_reg[CTRL_B_WGM_LSB +: 2], ctrl_a_reg[1:0]};
	wire logic       running  = ctrl_b_reg[CTRL_B_RUN];
	wire family_t    fam      = family_of(wgm);
	wire logic       is_fast  = (fam == FAM_FAST);
	wire logic       is_dual  = (fam == FAM_PHASE) || (fam == FAM_PFC);
	wire logic       non_pwm  = (fam == FAM_SINGLE);
	wire logic       reserved = (wgm == WGM_RESERVED);

	// TOP source per mode.
	logic [15:0] top_val;
	always_comb begin
		case (wgm)
			WGM_PC8, WGM_FAST8:                                 top_val = TOP_8BIT;
			WGM_PC9, WGM_FAST9:                                 top_val = TOP_9BIT;
			WGM_PC10, WGM_FAST10:                               top_val = TOP_10BIT;
			WGM_CTC_CMP, WGM_PFC_CMP, WGM_PC_CMP, WGM_FAST_CMP: top_val = cmp_a_reg;
			WGM_CTC_CAP, WGM_PFC_CAP, WGM_PC_CAP, WGM_FAST_CAP: top_val = capture_reg;
			default:                                            top_val = TOP_MAX;
		endcase
	end

	// Toggle mode 01 in PWM families works on channel A only in listed modes.
	wire logic tog_ok_a = non_pwm
		|| (is_fast && (wgm == WGM_FAST_CMP))
		|| (is_dual && ((wgm == WGM_PFC_CMP) || (wgm == WGM_FAST_CAP)));
	wire logic conn_a = (om_a != OM_OFF) && ((om_a != OM_TOGGLE) || tog_ok_a);
	wire logic conn_b = (om_b != OM_OFF) && ((om_b != OM_TOGGLE) || non_pwm);

	// ----------------------------------------------------------------
	// Counter events
	// ----------------------------------------------------------------
	wire logic at_top    = (count_reg == top_val);
	wire logic at_bottom = (count_reg == BOTTOM);
	wire logic tick      = clk_en && running && !reserved;
	wire logic match_a   = tick && (count_reg == cmp_a_reg);
	wire logic match_b   = tick && (count_reg == cmp_b_reg);

	// Next count: single slope wraps at TOP, dual slope turns at TOP and BOTTOM.
	logic [15:0] count_next;
	logic        up_next;
	always_comb begin
		count_next = count_reg;
		up_next    = up_reg;
		if (is_dual) begin
			if (up_reg && at_top) begin
				up_next    = 1'b0;
				count_next = count_reg - 16'h0001;
			end else if (!up_reg && at_bottom) begin
				up_next    = 1'b1;
				count_next = count_reg + 16'h0001;
			end else begin
				count_next = up_reg ? count_reg + 16'h0001 : count_reg - 16'h0001;
			end
		end else begin
			up_next    = 1'b1;
			count_next = (at_top && (wgm != WGM_NORMAL)) ? BOTTOM : count_reg + 16'h0001;
		end
	end

	// Compare buffer load point and overflow point per family.
	wire logic load_cmp = non_pwm
		|| ((fam == FAM_PFC) && at_bottom)
		|| (((fam == FAM_PHASE) || is_fast) && at_top);
	wire logic ovf_evt = tick && (
		(non_pwm && (count_reg == TOP_MAX))
		|| (is_fast && at_top)
		|| (is_dual && at_bottom && !up_reg));

	// ----------------------------------------------------------------
	// Waveform output next values
	// ----------------------------------------------------------------
	wire logic       ctrl_a_wr = bus_req.wr && (bus_req.addr == ADDR_CTRL_A);
	// A forced match acts with the mode and output fields carried by the same write.
	wire logic [3:0] wgm_wr    = {ctrl_b_reg[CTRL_B_WGM_LSB +: 2], bus_req.wdata[1:0]};
	wire logic       wr_single = (family_of(wgm_wr) == FAM_SINGLE);
	wire logic [1:0] frc_om_a  = bus_req.wdata[CTRL_A_OUT_A_LSB +: 2];
	wire logic [1:0] frc_om_b  = bus_req.wdata[CTRL_A_OUT_B_LSB +: 2];
	wire logic       force_a   = ctrl_a_wr && bus_req.wdata[CTRL_A_FORCE_A] && wr_single;
	wire logic       force_b   = ctrl_a_wr && bus_req.wdata[CTRL_A_FORCE_B] && wr_single;
	wire logic       top_evt   = tick && at_top;

	// Event decode for one channel; every input is an argument so the net follows all of them.
	function automatic logic chan_next(input logic cur, input logic [1:0] om, input logic m, input logic frc,
		input logic [1:0] frc_om, input logic cmp_is_top, input logic tog_ok, input logic single,
		input logic fast, input logic top_ev, input logic up);
		logic v;
		v = cur;
		if (frc) begin
			v = apply_out(cur, frc_om);
		end else if (single) begin
			if (m)
				v = apply_out(cur, om);
		end else if (om == OM_TOGGLE) begin
			if (m && tog_ok)
				v = ~cur;
		end else if (fast) begin
			if (m && !cmp_is_top)
				v = (om == OM_SET);
			if (top_ev)
				v = (om == OM_CLEAR);
		end else if (m) begin
			v = (om == OM_CLEAR) ? !up : up;
		end
		return v;
	endfunction : chan_next

	wire logic wave_a_next = chan_next(wave_a_reg, om_a, match_a, force_a, frc_om_a, cmp_a_reg == top_val, tog_ok_a,
		non_pwm, is_fast, top_evt, up_reg);
	wire logic wave_b_next = chan_next(wave_b_reg, om_b, match_b, force_b, frc_om_b, cmp_b_reg == top_val, 1'b0,
		non_pwm, is_fast, top_evt, up_reg);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic [15:0] rd_mux;
	always_comb begin
		case (bus_req.addr)
			ADDR_CTRL_A:  rd_mux = {8'h00, ctrl_a_reg[7:4], 2'h0, ctrl_a_reg[1:0]};
			ADDR_CTRL_B:  rd_mux = {8'h00, ctrl_b_reg};
			ADDR_CMP_A:   rd_mux = cmp_a_buf_reg;
			ADDR_CMP_B:   rd_mux = cmp_b_buf_reg;
			ADDR_CAPTURE: rd_mux = capture_reg;
			ADDR_COUNT:   rd_mux = count_reg;
			ADDR_STATUS:  rd_mux = {13'h0000, up_reg, wave_b_reg, wave_a_reg};
			default:      rd_mux = WORD_RESET;
		endcase
	end

	// Control and buffer registers; mode fields act from the next cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_a_reg    <= CTRL_RESET;
			ctrl_b_reg    <= CTRL_RESET;
			cmp_a_buf_reg <= WORD_RESET;
			cmp_b_buf_reg <= WORD_RESET;
			capture_reg   <= WORD_RESET;
			rdata_reg     <= WORD_RESET;
		end else if (clk_en) begin
			if (ctrl_a_wr)
				ctrl_a_reg <= {bus_req.wdata[7:4], 2'h0, bus_req.wdata[1:0]};
			if (bus_req.wr && (bus_req.addr == ADDR_CTRL_B))
				ctrl_b_reg <= {3'h0, bus_req.wdata[4:3], 2'h0, bus_req.wdata[0]};
			if (bus_req.wr && (bus_req.addr == ADDR_CMP_A))
				cmp_a_buf_reg <= bus_req.wdata;
			if (bus_req.wr && (bus_req.addr == ADDR_CMP_B))
				cmp_b_buf_reg <= bus_req.wdata;
			if (bus_req.wr && (bus_req.addr == ADDR_CAPTURE))
				capture_reg <= bus_req.wdata;
			rdata_reg <= bus_req.rd ? rd_mux : WORD_RESET;
		end
	end

	// Active compare values follow the buffers at the mode's update point.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_a_reg <= WORD_RESET;
			cmp_b_reg <= WORD_RESET;
		end else if (clk_en && (load_cmp && (tick || non_pwm))) begin
			cmp_a_reg <= cmp_a_buf_reg;
			cmp_b_reg <= cmp_b_buf_reg;
		end
	end

	// Counter, direction and overflow flag; a forced match touches neither.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= WORD_RESET;
			up_reg    <= 1'b1;
			flag_reg  <= 1'b0;
		end else if (clk_en) begin
			if (bus_req.wr && (bus_req.addr == ADDR_COUNT))
				count_reg <= bus_req.wdata;
			else if (tick) begin
				count_reg <= count_next;
				up_reg    <= up_next;
			end
			if (ovf_evt)
				flag_reg <= 1'b1;
			else if (bus_req.wr && (bus_req.addr == ADDR_STATUS) && bus_req.wdata[0])
				flag_reg <= 1'b0;
		end
	end

	// Waveform output state and pin override drive.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_a_reg <= 1'b0;
			wave_b_reg <= 1'b0;
			override_a <= 1'b0;
			override_b <= 1'b0;
		end else if (clk_en) begin
			wave_a_reg <= wave_a_next;
			wave_b_reg <= wave_b_next;
			override_a <= conn_a;
			override_b <= conn_b;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata         = rdata_reg;
	assign wave_out_a    = wave_a_reg;
	assign wave_out_b    = wave_b_reg;
	assign overflow_flag = flag_reg;
	assign count_up      = up_reg;

endmodule : wave_ctrl
`default_nettype wire

// File: verif/wave_pin.sv
// Model of a waveform pin shared with the ordinary port logic.
`timescale 1ns/100ps
`default_nettype none
module wave_pin (
	input  wire logic own,
	input  wire logic wave,
	input  wire logic dir_out,
	input  wire logic port_lvl,
	output var  logic pin
);
	// The pin sits at its pull-up level unless the direction bit enables the driver.
	always_comb begin
		if (!dir_out) begin
			pin = 1'b1;
		end else begin
			pin = own ? wave : port_lvl;
		end
	end
endmodule : wave_pin
`default_nettype wire

// File: verif/wave_ctrl_properties.sv
// Checker of the waveform controller behaviour at its ports.
`timescale 1ns/100ps
`default_nettype none
module wave_ctrl_properties
	import wave_ctrl_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        clk_en,
	input wire bus_req_t    bus_req,
	input wire logic [15:0] rdata,
	input wire logic        wave_out_a,
	input wire logic        override_a,
	input wire logic        override_b,
	input wire logic        overflow_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// ------------------------------------------------------------
	// Shadow copy of the mode fields
	// ------------------------------------------------------------
	logic [7:0] ctl_reg;
	logic [1:0] hi_reg;
	logic       run_reg;
	logic [1:0] age_reg;
	// Decodes of the taken writes and of the shadowed mode.
	wire logic       wr_a  = clk_en && bus_req.wr && bus_req.addr == ADDR_CTRL_A;
	wire logic       wr_b  = clk_en && bus_req.wr && bus_req.addr == ADDR_CTRL_B;
	wire logic [3:0] mode  = {hi_reg, ctl_reg[1:0]};
	wire logic [1:0] om_a  = ctl_reg[7:6];
	wire logic       calm  = age_reg == 2'h2;
	wire logic       pwm   = !(mode inside {WGM_NORMAL, WGM_CTC_CMP, WGM_CTC_CAP});
	wire logic       fast  = mode inside {WGM_FAST8, WGM_FAST9, WGM_FAST10, WGM_FAST_CAP, WGM_FAST_CMP};
	wire logic       phase = mode inside {WGM_PC8, WGM_PC9, WGM_PC10, WGM_PFC_CAP, WGM_PFC_CMP, WGM_PC_CAP, WGM_PC_CMP};
	wire logic       frc   = wr_a && bus_req.wdata[3] && !run_reg && !pwm && bus_req.wdata[1:0] == ctl_reg[1:0];
	// The age counts quiet cycles since the last mode write, so outputs are judged once settled.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_reg <= 8'h00;
			hi_reg <= 2'h0;
			run_reg <= 1'b0;
			age_reg <= 2'h2;
		end else begin
			if (wr_a) ctl_reg <= bus_req.wdata[7:0];
			if (wr_b) hi_reg <= bus_req.wdata[4:3];
			if (wr_b) run_reg <= bus_req.wdata[0];
			if (wr_a || wr_b) age_reg <= 2'h0;
			else if (clk_en && age_reg != 2'h2) age_reg <= age_reg + 2'h1;
		end
	end
	property p_off_a;
		calm && om_a == OM_OFF |-> !override_a;
	endproperty
	a_off_a: assert property (p_off_a) else $error("pin A owned while disconnected");
	property p_own_a;
		calm && !pwm && om_a != OM_OFF |-> override_a;
	endproperty
	a_own_a: assert property (p_own_a) else $error("pin A not owned in non-PWM mode");
	property p_fast_b;
		calm && fast && ctl_reg[5:4] == OM_TOGGLE |-> !override_b;
	endproperty
	a_fast_b: assert property (p_fast_b) else $error("pin B owned by toggle in fast PWM");
	property p_top_a;
		calm && mode == WGM_FAST_CMP && om_a == OM_TOGGLE |-> override_a;
	endproperty
	a_top_a: assert property (p_top_a) else $error("pin A not owned by toggle in mode 15");
	property p_phase_a;
		calm && phase && om_a == OM_TOGGLE |-> override_a == (mode == WGM_PFC_CMP);
	endproperty
	a_phase_a: assert property (p_phase_a) else $error("wrong pin A ownership in phase PWM");
	property p_force_set;
		frc && bus_req.wdata[7:6] == OM_SET |=> wave_out_a;
	endproperty
	a_force_set: assert property (p_force_set) else $error("forced set did not raise A");
	property p_force_flag;
		frc && !overflow_flag |=> !overflow_flag [*2];
	endproperty
	a_force_flag: assert property (p_force_flag) else $error("forced match raised the flag");
	property p_read_zero;
		clk_en && bus_req.rd && bus_req.addr == ADDR_CTRL_A |=> rdata[3:2] == 2'h0 && rdata[15:8] == 8'h00;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("force bits read back nonzero");
	// Main scenarios reached by the bench.
	c_force: cover property (frc);
	c_phase: cover property (calm && phase && om_a == OM_TOGGLE);
	c_flag: cover property ($rose(overflow_flag));
endmodule : wave_ctrl_properties
bind wave_ctrl wave_ctrl_properties chk (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .bus_req(bus_req),
	.rdata(rdata), .wave_out_a(wave_out_a), .override_a(override_a), .override_b(override_b),
	.overflow_flag(overflow_flag));
`default_nettype wire

// File: verif/wave_ctrl_tb.sv
// Self-checking testbench of the waveform controller.
`timescale 1ns/100ps
`default_nettype none
module wave_ctrl_tb;
	import wave_ctrl_pkg::*;
	logic        core_clk, arst_n, clk_en, wa, wb, oa, ob, ovf, up, pa, pb, port_lvl;
	logic [15:0] rdata, d, v;
	bus_req_t    req;
	int          err_total, num_checks, m, om, ea, n;
	int          seed = 32'hF08896A8;
	int          seq[$] = '{2, 1, 1, 3, 1, 2};
	wave_ctrl dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .bus_req(req), .rdata(rdata),
		.wave_out_a(wa), .wave_out_b(wb), .override_a(oa), .override_b(ob), .overflow_flag(ovf), .count_up(up));
	wave_pin pin_a (.own(oa), .wave(wa), .dir_out(1'b1), .port_lvl(port_lvl), .pin(pa));
	wave_pin pin_b (.own(ob), .wave(wb), .dir_out(1'b0), .port_lvl(port_lvl), .pin(pb));
	// ------------------------------------------------------------
	// Clock, tasks and expectation model
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus_wr(input logic [2:0] a, input logic [15:0] w);
		@(posedge core_clk);
		req.addr <= a;
		req.wdata <= w;
		req.wr <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [2:0] a, output logic [15:0] r);
		@(posedge core_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1;
		r = rdata;
	endtask : bus_rd
	// Pin ownership expected for a mode number, an output mode code and a channel.
	function automatic logic [15:0] ovr(input int md, input int o, input int ch);
		if (o == 0) return 16'h0000;
		if (md == 0 || md == 4 || md == 12 || o > 1) return 16'h0001;
		return (ch == 0 && (md == 9 || md == 15)) ? 16'h0001 : 16'h0000;
	endfunction : ovr
	// Stops, loads and restarts the counter, then sees whether the flag rises soon.
	task automatic run_mode(input int md, input logic [15:0] start, input logic [15:0] quick);
		bus_wr(ADDR_CTRL_B, 16'h0000);
		bus_wr(ADDR_STATUS, 16'h0001);
		bus_wr(ADDR_COUNT, start);
		bus_wr(ADDR_CTRL_A, 16'(md & 3));
		bus_wr(ADDR_CTRL_B, 16'(((md >> 2) << 3) | 1));
		n = 0;
		while (ovf !== 1'b1 && n < 24) begin
			@(posedge core_clk);
			n++;
		end
		#1;
		check("quick_flag", 16'(ovf), quick);
	endtask : run_mode
	task results;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		req = '0;
		clk_en = 1'b1;
		arst_n = 1'b0;
		port_lvl = 1'b0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		bus_rd(3'h7, d);
		check("unmapped", d, 16'h0000);
		for (m = 0; m < 16; m++) begin
			for (om = 0; om < 4; om++) begin
				bus_wr(ADDR_CTRL_B, 16'((m >> 2) << 3));
				bus_wr(ADDR_CTRL_A, 16'((om << 6) | (om << 4) | (m & 3)));
				repeat (2) @(posedge core_clk);
				#1;
				if (m != 13) begin
					check("override_a", 16'(oa), ovr(m, om, 0));
					check("override_b", 16'(ob), ovr(m, om, 1));
				end
			end
		end
		// Forced matches in normal mode with the counter stopped.
		bus_wr(ADDR_CTRL_B, 16'h0000);
		ea = 0;
		foreach (seq[i]) begin
			om = seq[i];
			port_lvl <= 1'($random(seed));
			bus_wr(ADDR_CTRL_A, 16'((om << 6) | (om << 4) | 12));
			#1;
			ea = (om == 1) ? 1 - ea : om & 1;
			check("wave_a", 16'(wa), 16'(ea));
			check("wave_b", 16'(wb), 16'(ea));
			check("pin_a", 16'(pa), 16'(ea));
			check("pin_b", 16'(pb), 16'h0001);
			bus_rd(ADDR_CTRL_A, d);
			check("ctrl_a", d, 16'((om << 6) | (om << 4)));
		end
		bus_wr(ADDR_CTRL_B, 16'h0008);
		bus_wr(ADDR_CTRL_A, 16'h00FD);
		#1;
		check("pwm_force", 16'(wa), 16'h0000);
		v = 16'($random(seed));
		bus_wr(ADDR_CTRL_A, 16'h00C0);
		bus_wr(ADDR_COUNT, v);
		bus_wr(ADDR_CTRL_A, 16'h00C8);
		#1;
		check("ctc_force", 16'(wa), 16'h0001);
		check("ctc_flag", 16'(ovf), 16'h0000);
		bus_rd(ADDR_COUNT, d);
		check("ctc_count", d, v);
		run_mode(0, 16'hFFF8, 16'h0001);
		bus_wr(ADDR_STATUS, 16'h0001);
		#1;
		check("flag_clear", 16'(ovf), 16'h0000);
		run_mode(5, 16'h00F8, 16'h0001);
		run_mode(7, 16'h03F8, 16'h0001);
		run_mode(1, 16'h00F8, 16'h0000);
		check("down", 16'(up), 16'h0000);
		n = 0;
		while (ovf !== 1'b1 && n < 600) begin
			@(posedge core_clk);
			n++;
		end
		repeat (3) @(posedge core_clk);
		#1;
		check("bottom_flag", 16'(ovf), 16'h0001);
		check("up_again", 16'(up), 16'h0001);
		run_mode(13, 16'h0100, 16'h0000);
		bus_rd(ADDR_COUNT, d);
		check("reserved_hold", d, 16'h0100);
		// Fast PWM with clear on match: set at TOP, cleared at the match.
		bus_wr(ADDR_CTRL_B, 16'h0000);
		bus_wr(ADDR_CMP_A, 16'h0080);
		bus_wr(ADDR_COUNT, 16'h00FC);
		bus_wr(ADDR_CTRL_A, 16'h0081);
		bus_wr(ADDR_CTRL_B, 16'h0009);
		repeat (8) @(posedge core_clk);
		#1;
		check("fast_set_top", 16'(wa), 16'h0001);
		repeat (130) @(posedge core_clk);
		#1;
		check("fast_clr_match", 16'(wa), 16'h0000);
		// A low clock enable freezes the running counter.
		bus_wr(ADDR_COUNT, 16'h0010);
		clk_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		clk_en <= 1'b1;
		bus_rd(ADDR_COUNT, d);
		check("frozen_count", d, 16'h0011);
		results();
	end
	// Cuts a hung run short.
	initial begin
		#3000000;
		err_total++;
		results();
	end
endmodule : wave_ctrl_tb
`default_nettype wire
